// ---- test/i2c_master_model.sv ----
// Serial bus master model: drives clock and open-drain data line
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic clk_i,       // System clock paces the link
  input  wire logic sda_i,       // Resolved data line
  output logic      scl_o,       // Link clock, master only
  output logic      sda_oe_n_o   // Low pulls data line
);
  // ****************************************************
  // Link bit timing: 4 clocks low, 4 high (200 ns)
  // ****************************************************
  initial begin
    scl_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One bit, data moves only while clock low
  task automatic bit_x(input logic b, output logic r);
    wt(1);
    sda_oe_n_o <= b;
    wt(3);
    scl_o <= 1'b1;
    wt(4);
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  // Start or repeated start, data falls while clock high
  task automatic start;
    wt(1);
    sda_oe_n_o <= 1'b1;
    wt(3);
    scl_o <= 1'b1;
    wt(4);
    sda_oe_n_o <= 1'b0;
    wt(4);
    scl_o <= 1'b0;
  endtask
  // Stop, data rises while clock high
  task automatic stop;
    wt(1);
    sda_oe_n_o <= 1'b0;
    wt(3);
    scl_o <= 1'b1;
    wt(4);
    sda_oe_n_o <= 1'b1;
    wt(4);
  endtask
  // Nine-clock group, MSB first, last bit is acknowledge
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
  endtask
endmodule

// ---- test/tb_charger_i2c_slave_port.sv ----
// Self-checking bench for the charger serial slave port
`timescale 1ns/1ps
module tb_charger_i2c_slave_port;
  import chg_i2c_pkg::*;
  logic        clk_i, rst_i, cyc, we, ack, scl, m_oe_n, d_oe_n, d_sda, hs;
  logic [7:0]  adr;    // Bus address
  logic [31:0] wdat;   // Bus write data
  logic [31:0] rdat;   // Bus read data
  logic [31:0] r;      // Last read word
  logic [8:0]  q;      // Last serial group
  logic [2:0]  tt;     // Termination field
  logic [3:0]  cc;     // Charge field
  logic [15:0] tuv;    // Termination voltage
  logic [17:0] cuv;    // Charge voltage
  wire         sda = (d_oe_n | d_sda) & m_oe_n;  // Pull-up wired AND
  int          fail_count = 0;
  int          num_checks = 0;
  charger_i2c_slave_port DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i(scl), .sda_i(sda),
    .sda_o(d_sda), .sda_oe_n_o(d_oe_n), .term_thresh_o(tt), .chg_current_o(cc),
    .term_uv_o(tuv), .chg_uv_o(cuv), .hs_mode_o(hs));
  i2c_master_model m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(m_oe_n));
  // ****************************************************
  // Clock, compare, bus and report tasks
  // ****************************************************
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  // Classic single cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_write;
    m.start();
    m.xfer({8'hD6, 1'b1}, q);
    chk(q[0], 0);
    m.xfer({8'h00, 1'b1}, q);
    chk(q[0], 0);
    m.xfer({8'h2B, 1'b1}, q);
    chk(q[0], 0);
    m.stop();
    chk(tt, 3'h3);
    chk(cc, 4'h5);
    chk(tuv, 16'h1A90);
    chk(cuv, 18'h116E8);
    wb(1'b0, 8'h04, 0);
    chk(r, 32'h2B);
    $display("write test done");
  endtask
  task automatic t_read;
    m.start();
    m.xfer({8'hD6, 1'b1}, q);
    m.xfer({8'h00, 1'b1}, q);
    m.start();
    m.xfer({8'hD7, 1'b1}, q);
    chk(q[0], 0);
    m.xfer({8'hFF, 1'b0}, q);
    chk(q[8:1], 8'h2B);
    m.xfer({8'hFF, 1'b0}, q);
    chk(q[8:1], 8'h01);
    m.xfer({8'hFF, 1'b1}, q);
    chk(q[8:1], 8'hFF);
    m.stop();
    chk(d_oe_n, 1);
    $display("read test done");
  endtask
  task automatic t_refuse;
    m.start();
    m.xfer({8'hD4, 1'b1}, q);
    chk(q[0], 1);
    m.stop();
    m.start();
    m.xfer({8'h08, 1'b1}, q);
    chk(q[0], 1);
    chk(hs, 1);
    m.start();
    m.xfer({8'hD6, 1'b1}, q);
    chk(q[0], 0);
    m.stop();
    chk(hs, 0);
    wb(1'b0, 8'h08, 0);
    chk(r, 0);
    $display("refuse test done");
  endtask
  // Full-scale fields over the bus, serial read-back, port disable
  task automatic t_regs;
    wb(1'b1, 8'h04, 32'h7F);
    chk(tt, 3'h7);
    chk(cc, 4'hF);
    chk(tuv, 16'h3520);
    chk(cuv, 18'h22088);
    m.start();
    m.xfer({8'hD6, 1'b1}, q);
    m.xfer({8'h00, 1'b1}, q);
    m.start();
    m.xfer({8'hD7, 1'b1}, q);
    m.xfer({8'hFF, 1'b1}, q);
    chk(q[8:1], 8'h7F);
    m.stop();
    wb(1'b1, 8'h00, 0);
    wb(1'b0, 8'h00, 0);
    chk(r, 0);
    m.start();
    m.xfer({8'hD6, 1'b1}, q);
    chk(q[0], 1);
    m.stop();
    wb(1'b1, 8'h00, 1);
    wb(1'b0, 8'h00, 0);
    chk(r, 1);
    $display("register test done");
  endtask
  // ****************************************************
  // Main sequence and watchdog
  // ****************************************************
  initial begin
    rst_i = 1'b1;
    {cyc, we, adr, wdat} = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(tuv, 16'h06A4);
    chk(cuv, 18'h09218);
    chk(d_oe_n, 1);
    t_write();
    t_read();
    t_refuse();
    t_regs();
    final_report();
  end
  initial begin
    #400000;
    fail_count++;
    final_report();
  end
endmodule

// ---- verilog/charger_i2c_slave_port.sv ----
// Serial slave port carrying charger parameters, with a Wishbone register window
//
// How it works
// - Device is slave only; master drives clock
// - Runs standard, fast and high-speed bit rates
// - Answers only 7-bit address 6B hex
// - Start is data falling while clock high
// - Stop releases bus, waits for start
// - Data line changes only while clock low
// - Seven address bits compared, direction bit only stored
// - Matching address pulled low on ninth clock
// - Receiver acknowledges every data byte
// - Nine-clock groups repeat until stop
// - Stop returns machine to idle always
// - Unimplemented serial register reads return FF hex
// - Termination field: 6.8/3.4/1.7 mV plus 1.7
// - Charge field: 54.4/27.2/13.6/6.8 plus 37.4
// - Code 00001xxx enters high speed until stop
`timescale 1ns/1ps
module charger_i2c_slave_port
  import chg_i2c_pkg::*;
(
  input  wire logic        clk_i,                    // 40 MHz system clock
  input  wire logic        rst_i,                    // Synchronous reset
  input  wire logic        wb_cyc_i,                 // Wishbone cycle
  input  wire logic        wb_stb_i,                 // Wishbone strobe
  input  wire logic        wb_we_i,                  // Wishbone write
  input  wire logic [7:0]  wb_adr_i,                 // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,                 // Wishbone byte select
  input  wire logic [31:0] wb_dat_i,                 // Wishbone write data
  output logic [31:0]      wb_dat_o,                 // Wishbone read data
  output logic             wb_ack_o,                 // Wishbone acknowledge
  input  wire logic        scl_i,                    // Serial clock pin
  input  wire logic        sda_i,                    // Serial data pin level
  output logic             sda_o,                    // Serial data drive value
  output logic             sda_oe_n_o,               // Low while pulling data
  output logic [2:0]       term_thresh_o,            // Termination field
  output logic [3:0]       chg_current_o,            // Charge current field
  output logic [15:0]      term_uv_o,                // Termination sense voltage
  output logic [17:0]      chg_uv_o,                 // Charge sense voltage
  output logic             hs_mode_o                 // High-speed mode active
);

  slave_state_type s;                                // Current state
  slave_state_type next_s;                           // Next state
  logic            scl_s;                            // Synced clock
  logic            sda_s;                            // Synced data
  logic            scl_rise;                         // Clock rising
  logic            scl_fall;                         // Clock falling
  logic            start_det;                        // Start or repeated start
  logic            stop_det;                         // Stop

  // ****************************************************
  // Pin synchroniser
  // ****************************************************
  pin_edge_sync u_sync (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .scl_o      (scl_s),
    .sda_o      (sda_s),
    .scl_rise_o (scl_rise),
    .scl_fall_o (scl_fall),
    .start_o    (start_det),
    .stop_o     (stop_det)
  );

  // ****************************************************
  // Serial register read mux
  // ****************************************************

  // Byte returned for a serial register index
  function automatic logic [7:0] read_byte(input logic [7:0] idx, input slave_state_type st);
    logic [7:0] b;
    b = NOT_IMPL_BYTE;
    if (idx == SREG_PARAM) begin
      b = {1'b0, st.param};
    end else if (idx == SREG_STATUS) begin
      b = {6'h00, st.hs_mode, st.enable};
    end
    return b;
  endfunction

  // ****************************************************
  // Next state logic
  // ****************************************************

  // Bus slave, serial engine and voltage decode
  always_comb begin
    logic [7:0] rb;
    rb       = 8'h00;
    next_s   = s;
    next_s.ack = 1'b0;
    // Wishbone single-cycle answer, one wait state
    if (wb_cyc_i && wb_stb_i && !s.ack) begin
      next_s.ack   = 1'b1;
      next_s.rdata = 32'h0000_0000;
      unique case (wb_adr_i)
        // Enable bit steers address matching
        WB_CTRL: begin
          next_s.rdata[CTRL_EN_BIT] = s.enable;
          if (wb_we_i && wb_sel_i[0]) begin
            next_s.enable = wb_dat_i[CTRL_EN_BIT];
          end
        end
        // Parameter byte, also writable by the serial master
        WB_PARAM: begin
          next_s.rdata[PARAM_W-1:0] = s.param;
          if (wb_we_i && wb_sel_i[0]) begin
            next_s.param = wb_dat_i[PARAM_W-1:0];
          end
        end
        // Read-only live state
        WB_STATUS: begin
          next_s.rdata[ST_BUSY_BIT] = (s.phase != PH_IDLE);
          next_s.rdata[ST_HS_BIT]   = s.hs_mode;
          next_s.rdata[ST_RW_BIT]   = s.rw;
        end
        // Unmapped: acknowledged, reads zero, writes dropped
        default: begin
          next_s.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Serial engine; line is only ever released or pulled low
    if (stop_det) begin
      // Abort anything in progress and leave high-speed mode
      next_s.phase    = PH_IDLE;
      next_s.sda_oe_n = 1'b1;
      next_s.hs_mode  = 1'b0;
    end else if (start_det) begin
      // Start or repeated start; high-speed survives a repeat
      next_s.phase     = PH_ADDR;
      next_s.bit_cnt   = 4'h0;
      next_s.sda_oe_n  = 1'b1;
      next_s.ptr_phase = 1'b1;
    end else begin
      unique case (s.phase)
        // Wait for start
        PH_IDLE: begin
          next_s.sda_oe_n = 1'b1;
        end
        // Receive address and direction, or a written byte
        PH_ADDR, PH_WDATA: begin
          if (scl_rise && s.bit_cnt < BITS_PER_BYTE) begin
            next_s.sh      = {s.sh[6:0], sda_s};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end else if (scl_fall && s.bit_cnt == BITS_PER_BYTE) begin
            if (s.phase == PH_WDATA) begin
              // Acknowledge every written byte
              next_s.sda_oe_n = 1'b0;
              next_s.phase    = PH_WACK;
              if (s.ptr_phase) begin
                next_s.ptr       = s.sh;
                next_s.ptr_phase = 1'b0;
              end else begin
                if (s.ptr == SREG_PARAM) begin
                  next_s.param = s.sh[PARAM_W-1:0];
                end
                next_s.ptr = s.ptr + 8'h01;
              end
            end else if (s.sh[7:1] == SLAVE_ADDR && s.enable) begin
              // Our address: pull low through ninth clock
              next_s.sda_oe_n = 1'b0;
              next_s.rw       = s.sh[0];
              next_s.phase    = PH_ADDR_ACK;
            end else if (s.sh[7:3] == HS_CODE_TOP) begin
              // Master code: never acknowledged, switch rate
              next_s.hs_mode = 1'b1;
              next_s.phase   = PH_IDLE;
            end else begin
              // Other address: stay released
              next_s.phase = PH_IDLE;
            end
          end
        end
        // Release acknowledge after ninth clock
        PH_ADDR_ACK, PH_WACK: begin
          if (scl_fall) begin
            next_s.sda_oe_n = 1'b1;
            next_s.bit_cnt  = 4'h0;
            if (s.phase == PH_ADDR_ACK && s.rw) begin
              // Read: first bit goes out on this low phase
              rb              = read_byte(s.ptr, s);
              next_s.sh       = rb;
              next_s.sda_oe_n = rb[7];
              next_s.ptr      = s.ptr + 8'h01;
              next_s.phase    = PH_RDATA;
            end else begin
              next_s.phase = PH_WDATA;
            end
          end
        end
        // Transmit a byte, changing data only after falling clock
        PH_RDATA: begin
          if (scl_rise) begin
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (s.bit_cnt == BITS_PER_BYTE) begin
              next_s.sda_oe_n = 1'b1;
              next_s.phase    = PH_RACK;
            end else begin
              next_s.sh       = {s.sh[6:0], 1'b0};
              next_s.sda_oe_n = s.sh[6];
            end
          end
        end
        // Master acknowledges; no acknowledge ends sending
        PH_RACK: begin
          if (scl_rise) begin
            next_s.mack = ~sda_s;
          end else if (scl_fall) begin
            next_s.bit_cnt = 4'h0;
            if (s.mack) begin
              rb              = read_byte(s.ptr, s);
              next_s.sh       = rb;
              next_s.sda_oe_n = rb[7];
              next_s.ptr      = s.ptr + 8'h01;
              next_s.phase    = PH_RDATA;
            end else begin
              next_s.phase = PH_IDLE;
            end
          end
        end
      endcase
    end

    // Sense voltages from the stored fields
    next_s.term_uv = TERM_OFS_UV
                   + (next_s.param[TERM_LSB+2] ? TERM_W2_UV : 16'h0000)
                   + (next_s.param[TERM_LSB+1] ? TERM_W1_UV : 16'h0000)
                   + (next_s.param[TERM_LSB]   ? TERM_W0_UV : 16'h0000);
    next_s.chg_uv  = CHG_OFS_UV
                   + (next_s.param[CHG_LSB+3] ? CHG_W3_UV : 18'h00000)
                   + (next_s.param[CHG_LSB+2] ? CHG_W2_UV : 18'h00000)
                   + (next_s.param[CHG_LSB+1] ? CHG_W1_UV : 18'h00000)
                   + (next_s.param[CHG_LSB]   ? CHG_W0_UV : 18'h00000);
  end

  // ****************************************************
  // State register
  // ****************************************************

  // All state in one record
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s          <= '0;
      s.phase    <= PH_IDLE;
      s.sda_oe_n <= 1'b1;
      s.enable   <= ENABLE_RST;
      s.param    <= PARAM_RST;
      s.term_uv  <= TERM_OFS_UV;
      s.chg_uv   <= CHG_OFS_UV;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************
  // Outputs, all straight from the record except sda_o, tied low
  // ****************************************************
  assign wb_dat_o      = s.rdata;
  assign wb_ack_o      = s.ack;
  assign sda_o         = 1'b0;
  assign sda_oe_n_o    = s.sda_oe_n;
  assign term_thresh_o = s.param[TERM_LSB+2:TERM_LSB];
  assign chg_current_o = s.param[CHG_LSB+3:CHG_LSB];
  assign term_uv_o     = s.term_uv;
  assign chg_uv_o      = s.chg_uv;
  assign hs_mode_o     = s.hs_mode;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_stop_to_idle: assert property (
    stop_det |=> (s.phase == PH_IDLE) && sda_oe_n_o && !hs_mode_o)
    else $error("stop did not return port to idle");

  a_start_to_addr: assert property (
    (start_det && !stop_det) |=> (s.phase == PH_ADDR) && (s.bit_cnt == 4'h0))
    else $error("start did not begin address phase");

  a_addr_match_ack: assert property (
    (s.phase == PH_ADDR && scl_fall && !start_det && !stop_det && s.bit_cnt == 4'h8
     && s.sh[7:1] == 7'h6B && s.enable) |=> !sda_oe_n_o ##0 (s.phase == PH_ADDR_ACK))
    else $error("matching address not acknowledged");

  a_addr_miss_free: assert property (
    (s.phase == PH_ADDR && scl_fall && !start_det && !stop_det && s.bit_cnt == 4'h8
     && s.sh[7:1] != 7'h6B) |=> sda_oe_n_o)
    else $error("foreign address pulled data line");

  a_change_low_only: assert property (
    ($changed(sda_oe_n_o) && !$past(start_det) && !$past(stop_det)) |-> !$past(scl_s))
    else $error("data line changed while clock high");

  a_write_ack: assert property (
    (s.phase == PH_WDATA && scl_fall && !start_det && !stop_det && s.bit_cnt == 4'h8)
    |=> !sda_oe_n_o && (s.phase == PH_WACK))
    else $error("written byte not acknowledged");

  a_nine_clock: assert property (
    (s.phase == PH_RDATA && scl_fall && !start_det && !stop_det && s.bit_cnt == 4'h8)
    |=> sda_oe_n_o && (s.phase == PH_RACK))
    else $error("transmitter held line in acknowledge slot");

  a_unimpl_ff: assert property (
    (s.phase == PH_RDATA && $past(s.phase) != PH_RDATA && $past(s.ptr) > 8'h01)
    |-> (s.sh == 8'hFF))
    else $error("unknown index did not read FF");

  a_hs_enter: assert property (
    (s.phase == PH_ADDR && scl_fall && !start_det && !stop_det && s.bit_cnt == 4'h8
     && s.sh[7:3] == 5'h01) |=> hs_mode_o && sda_oe_n_o)
    else $error("high-speed code not taken");

  a_read_dir: assert property (
    (s.phase == PH_ADDR_ACK && scl_fall && !start_det && !stop_det && s.rw)
    |=> (s.phase == PH_RDATA))
    else $error("direction one did not start read");

  a_term_full: assert property (
    term_thresh_o == 3'h7 |-> term_uv_o == 16'h3520)
    else $error("termination full scale not 13.6 mV");

  a_chg_full: assert property (
    chg_current_o == 4'hF |-> chg_uv_o == 18'h22088)
    else $error("charge full scale not 139.4 mV");

  a_wb_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");

  c_addr_acked: cover property (s.phase == PH_ADDR_ACK ##1 s.phase == PH_ADDR_ACK);
  c_write_data: cover property (s.phase == PH_WACK && !s.ptr_phase);
  c_read_byte:  cover property (s.phase == PH_RACK && s.mack);
  c_hs_mode:    cover property ($rose(hs_mode_o));

endmodule

// ---- verilog/chg_i2c_pkg.sv ----
// Shared constants, types and state records for the charger serial slave port
package chg_i2c_pkg;

  // ****************************************************
  // Serial bus identity and codes
  // ****************************************************
  localparam logic [6:0] SLAVE_ADDR    = 7'h6B;      // Fixed 7-bit slave address
  localparam logic [4:0] HS_CODE_TOP   = 5'h01;      // Upper five bits of 00001xxx
  localparam logic [7:0] NOT_IMPL_BYTE = 8'hFF;      // Read answer for unknown index
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;       // Data bits before acknowledge

  // ****************************************************
  // Serial register indices
  // ****************************************************
  localparam logic [7:0] SREG_PARAM  = 8'h00;        // Charge parameter byte
  localparam logic [7:0] SREG_STATUS = 8'h01;        // Port status byte, read only

  // ****************************************************
  // Wishbone register byte offsets and fields
  // ****************************************************
  localparam logic [7:0] WB_CTRL     = 8'h00;        // Port enable
  localparam logic [7:0] WB_PARAM    = 8'h04;        // Charge parameter mirror
  localparam logic [7:0] WB_STATUS   = 8'h08;        // Live port state
  localparam int         CTRL_EN_BIT = 0;            // Slave enable bit
  localparam int         ST_BUSY_BIT = 0;            // Transfer in progress
  localparam int         ST_HS_BIT   = 1;            // High-speed mode active
  localparam int         ST_RW_BIT   = 2;            // Last direction bit
  localparam int         PARAM_W     = 7;            // Parameter byte width
  localparam int         TERM_LSB    = 0;            // Termination field position
  localparam int         CHG_LSB     = 3;            // Charge current field position

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [6:0] PARAM_RST  = 7'h00;         // Lowest settings
  localparam logic       ENABLE_RST = 1'b1;          // Port answers after reset

  // ****************************************************
  // Sense voltage weights in microvolts
  // ****************************************************
  localparam logic [15:0] TERM_OFS_UV = 16'h06A4;    // 1.7 mV offset
  localparam logic [15:0] TERM_W2_UV  = 16'h1A90;    // 6.8 mV
  localparam logic [15:0] TERM_W1_UV  = 16'h0D48;    // 3.4 mV
  localparam logic [15:0] TERM_W0_UV  = 16'h06A4;    // 1.7 mV
  localparam logic [17:0] CHG_OFS_UV  = 18'h09218;   // 37.4 mV offset
  localparam logic [17:0] CHG_W3_UV   = 18'h0D480;   // 54.4 mV
  localparam logic [17:0] CHG_W2_UV   = 18'h06A40;   // 27.2 mV
  localparam logic [17:0] CHG_W1_UV   = 18'h03520;   // 13.6 mV
  localparam logic [17:0] CHG_W0_UV   = 18'h01A90;   // 6.8 mV

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_ADDR_ACK, PH_WDATA, PH_WACK, PH_RDATA, PH_RACK
  } phase_type;

  typedef struct packed {
    logic [1:0] meta;                                // First stage, {scl, sda}
    logic [1:0] sync;                                // Second stage
    logic [1:0] prev;                                // Previous synced value
  } pin_sync_type;

  typedef struct packed {
    phase_type   phase;                              // Serial phase
    logic [3:0]  bit_cnt;                            // Bits in current byte
    logic [7:0]  sh;                                 // Shift register
    logic        rw;                                 // Direction bit
    logic        ptr_phase;                          // Next written byte is index
    logic [7:0]  ptr;                                // Register index
    logic        mack;                               // Master acknowledged
    logic        hs_mode;                            // High-speed mode
    logic        sda_oe_n;                           // Low pulls data line
    logic        enable;                             // Software enable
    logic [6:0]  param;                              // Charge parameters
    logic [15:0] term_uv;                            // Termination sense voltage
    logic [17:0] chg_uv;                             // Charge sense voltage
    logic        ack;                                // Wishbone acknowledge
    logic [31:0] rdata;                              // Wishbone read data
  } slave_state_type;

endpackage

// ---- verilog/pin_edge_sync.sv ----
// Two-stage pin synchroniser with clock edge and start/stop detection
`timescale 1ns/1ps
module pin_edge_sync
  import chg_i2c_pkg::*;
(
  input  wire logic clk_i,                           // System clock
  input  wire logic rst_i,                           // Synchronous reset
  input  wire logic scl_i,                           // Raw clock pin
  input  wire logic sda_i,                           // Raw data pin
  output logic      scl_o,                           // Synced clock level
  output logic      sda_o,                           // Synced data level
  output logic      scl_rise_o,                      // Clock rose
  output logic      scl_fall_o,                      // Clock fell
  output logic      start_o,                         // Start seen
  output logic      stop_o                           // Stop seen
);

  pin_sync_type s;                                   // Current state
  pin_sync_type next_s;                              // Next state

  // ****************************************************
  // Synchroniser chain
  // ****************************************************

  // Shift both pins through two flops, then keep one older copy
  always_comb begin
    next_s      = s;
    next_s.meta = {scl_i, sda_i};
    next_s.sync = s.meta;
    next_s.prev = s.sync;
  end

  // Register the chain, idle bus reads high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************
  // Edge and condition decode
  // ****************************************************
  assign scl_o      = s.sync[1];
  assign sda_o      = s.sync[0];
  assign scl_rise_o = s.sync[1] & ~s.prev[1];
  assign scl_fall_o = ~s.sync[1] & s.prev[1];
  // Data falls while clock stays high
  assign start_o    = s.sync[1] & s.prev[1] & s.prev[0] & ~s.sync[0];
  // Data rises while clock stays high
  assign stop_o     = s.sync[1] & s.prev[1] & ~s.prev[0] & s.sync[0];

endmodule
